// ===== design/rexs_map.svh
// timing constants and counter widths for the remote exploder sequencer
`ifndef REXS_MAP_SVH
`define REXS_MAP_SVH
`define REXS_CLK_HZ          100000000
`define REXS_TICK_HZ         10
`define REXS_ARM_TIME_S      600
`define REXS_LOCK_TIME_S     2
`define REXS_TEST_TIME_S     20
`define REXS_TICK_DIV        (`REXS_CLK_HZ / `REXS_TICK_HZ)
`define REXS_ARM_TICKS       (`REXS_ARM_TIME_S * `REXS_TICK_HZ)
`define REXS_LOCK_TICKS      (`REXS_LOCK_TIME_S * `REXS_TICK_HZ)
`define REXS_TEST_TICKS      (`REXS_TEST_TIME_S * `REXS_TICK_HZ)
`define REXS_TCNT_W          16
`define REXS_DIV_W           32
`endif

// ===== design/rexs_pkg.sv
// types for the remote exploder sequencer
`default_nettype none
package rexs_pkg;
  typedef enum logic [2:0]
  {
    REXS_SAFE   = 3'b000,
    REXS_IDLE   = 3'b001,
    REXS_ARMED  = 3'b010,
    REXS_FIRING = 3'b011,
    REXS_LOCKED = 3'b100
  } rexs_state_e;
endpackage
`default_nettype wire

// ===== design/rexs_tick.sv
// slow tick divider
`timescale 1ns/10ps
`default_nettype none
`include "rexs_map.svh"
module rexs_tick
#(
  parameter int unsigned DIV = `REXS_TICK_DIV
)
(
  input  wire logic core_clk,
  input  wire logic reset_n,
  output logic      tick
);
  logic [`REXS_DIV_W-1:0] cnt_r;
  logic [`REXS_DIV_W-1:0] cnt_nxt;
  logic                   tick_r;
  logic                   tick_nxt;

  // a zero divider would wrap the compare and raise the tick only once every 2^32 cycles
  if (DIV < 1)
  begin
    $error("rexs_tick: DIV must be at least 1");
  end

  always_comb
  begin
    tick_nxt = 1'b0;
    cnt_nxt  = cnt_r + 32'h1;
    if (cnt_r >= DIV[`REXS_DIV_W-1:0] - 32'h1)
    begin
      cnt_nxt  = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule
`default_nettype wire

// ===== design/rexs_seq.sv
// remote exploder sequencer: key, prime, fire, timeout and lockout
// What this block does
// - key off keeps firing output terminals shorted.
// - key on keeps output shorted until a valid prime command.
// - capacitors shorted until prime, then released and charging.
// - prime lights priming lamp and enters armed state.
// - armed at most ten minutes; without fire, abort automatically.
// - after abort a fresh prime is needed before fire.
// - fire while armed connects charged capacitors to output.
// - two seconds after firing, lockout isolates output from battery and capacitors.
// - lockout reapplies short across output terminals.
// - while locked out, prime and fire are ignored.
// - while locked out, red fired-lockout lamp lit.
// - lockout holds until key returns to off.
// - key on activates display, self-test; green power lamp 20 s after key on if test passes.
// - receiving lamp lit once synchronised to paging signal.
// - line resistance shown continuously on display.
`timescale 1ns/10ps
`default_nettype none
`include "rexs_map.svh"
module rexs_seq
  import rexs_pkg::*;
#(
  parameter int unsigned TICK_DIV   = `REXS_TICK_DIV,
  parameter int unsigned ARM_TICKS  = `REXS_ARM_TICKS,
  parameter int unsigned LOCK_TICKS = `REXS_LOCK_TICKS,
  parameter int unsigned TEST_TICKS = `REXS_TEST_TICKS,
  parameter int unsigned RES_W      = 16
)
(
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic             key_on,
  input  wire logic             prime_cmd,
  input  wire logic             fire_cmd,
  input  wire logic             paging_synced,
  input  wire logic             self_test_ok,
  input  wire logic [RES_W-1:0] line_res_ohm,
  output logic                  output_short,
  output logic                  cap_short,
  output logic                  cap_charge,
  output logic                  cap_to_output,
  output logic                  output_isolate,
  output logic                  priming_lamp,
  output logic                  fired_lockout_lamp,
  output logic                  power_lamp,
  output logic                  receiving_lamp,
  output logic                  display_on,
  output logic [RES_W-1:0]      display_res_ohm,
  output logic                  abort_pulse
);
  import rexs_pkg::*;

  // counters are 16 bits wide; larger counts would wrap before timing out
  if (ARM_TICKS < 1 || LOCK_TICKS < 1 || TEST_TICKS < 1 || TEST_TICKS >= 65536 || ARM_TICKS >= 65536
      || LOCK_TICKS >= 65536 || TICK_DIV < 1 || RES_W < 1)
  begin
    $error("rexs_seq: tick counts must lie in 1..65535");
  end

  logic                    tick;
  rexs_state_e             state_r;
  rexs_state_e             state_nxt;
  logic [`REXS_TCNT_W-1:0] tcnt_r;
  logic [`REXS_TCNT_W-1:0] tcnt_nxt;
  logic [`REXS_TCNT_W-1:0] test_r;
  logic [`REXS_TCNT_W-1:0] test_nxt;
  logic                    pwr_r;
  logic                    pwr_nxt;
  logic                    rcv_r;
  logic                    rcv_nxt;
  logic [RES_W-1:0]        res_r;
  logic [RES_W-1:0]        res_nxt;
  logic                    abort_r;
  logic                    abort_nxt;

  rexs_tick #(.DIV(TICK_DIV)) u_tick
  (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .tick     (tick)
  );

  // sequencer
  always_comb
  begin
    state_nxt = state_r;
    abort_nxt = 1'b0;
    tcnt_nxt  = tick ? tcnt_r + 16'h1 : tcnt_r;
    case (state_r)
      REXS_SAFE:
      begin
        if (key_on)
        begin
          state_nxt = REXS_IDLE;
          tcnt_nxt  = '0;
        end
      end
      REXS_IDLE:
      begin
        // fire ignored here: unit not armed
        if (prime_cmd)
        begin
          state_nxt = REXS_ARMED;
          tcnt_nxt  = '0;
        end
      end
      REXS_ARMED:
      begin
        if (fire_cmd)
        begin
          state_nxt = REXS_FIRING;
          tcnt_nxt  = '0;
        end
        else if (tick && tcnt_r >= ARM_TICKS[15:0] - 16'h1)
        begin
          state_nxt = REXS_IDLE;
          abort_nxt = 1'b1;
          tcnt_nxt  = '0;
        end
      end
      REXS_FIRING:
      begin
        if (tick && tcnt_r >= LOCK_TICKS[15:0] - 16'h1)
        begin
          state_nxt = REXS_LOCKED;
          tcnt_nxt  = '0;
        end
      end
      REXS_LOCKED:
      begin
        // commands ignored until the key is turned off
        state_nxt = REXS_LOCKED;
      end
      default:
      begin
        state_nxt = REXS_SAFE;
      end
    endcase
    // key off always wins: safe from any state
    if (!key_on)
    begin
      state_nxt = REXS_SAFE;
      tcnt_nxt  = '0;
      abort_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= REXS_SAFE;
      tcnt_r  <= '0;
      abort_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      tcnt_r  <= tcnt_nxt;
      abort_r <= abort_nxt;
    end
  end

  // self-test, receiving and display
  always_comb
  begin
    test_nxt = test_r;
    pwr_nxt  = pwr_r;
    rcv_nxt  = key_on & paging_synced;
    res_nxt  = key_on ? line_res_ohm : '0;
    if (!key_on)
    begin
      test_nxt = '0;
      pwr_nxt  = 1'b0;
    end
    else if (test_r < TEST_TICKS[15:0])
    begin
      if (tick)
        test_nxt = test_r + 16'h1;
    end
    else
    begin
      // lamp only after the full 20 s, then tracks the test result
      pwr_nxt = self_test_ok;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      test_r <= '0;
      pwr_r  <= 1'b0;
      rcv_r  <= 1'b0;
      res_r  <= '0;
    end
    else
    begin
      test_r <= test_nxt;
      pwr_r  <= pwr_nxt;
      rcv_r  <= rcv_nxt;
      res_r  <= res_nxt;
    end
  end

  // outputs decoded from flops except display_on, which is key_on itself; no combinational prime/fire path
  assign output_short       = (state_r != REXS_ARMED) && (state_r != REXS_FIRING);
  assign cap_short          = (state_r == REXS_SAFE) || (state_r == REXS_IDLE);
  assign cap_charge         = (state_r == REXS_ARMED);
  assign cap_to_output      = (state_r == REXS_FIRING);
  assign output_isolate     = (state_r == REXS_LOCKED);
  assign priming_lamp       = (state_r == REXS_ARMED);
  assign fired_lockout_lamp = (state_r == REXS_LOCKED);
  assign power_lamp         = pwr_r;
  assign receiving_lamp     = rcv_r;
  assign display_on         = key_on;
  assign display_res_ohm    = res_r;
  assign abort_pulse        = abort_r;
endmodule
`default_nettype wire

// ===== tb/rexs_seq_sva.sv
// assertion checker for the remote exploder sequencer
`timescale 1ns/10ps
`default_nettype none
module rexs_seq_sva
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic key_on,
  input wire logic prime_cmd,
  input wire logic fire_cmd,
  input wire logic paging_synced,
  input wire logic output_short,
  input wire logic cap_short,
  input wire logic cap_to_output,
  input wire logic output_isolate,
  input wire logic priming_lamp,
  input wire logic fired_lockout_lamp,
  input wire logic receiving_lamp,
  input wire logic abort_pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_key_off_short: assert property (
    !key_on |=> output_short && cap_short) else $error("shorts missing with key off");
  a_prime_arms: assert property (
    key_on && $past(key_on) && $past(reset_n) && prime_cmd && output_short && !fired_lockout_lamp
    |=> priming_lamp && !output_short && !cap_short) else $error("prime did not arm");
  a_unarmed_fire: assert property (
    fire_cmd && output_short |=> !cap_to_output) else $error("fire accepted while unarmed");
  a_fire_connects: assert property (
    fire_cmd && key_on && priming_lamp |=> cap_to_output && !priming_lamp) else $error("fire not taken");
  a_lock_outputs: assert property (
    fired_lockout_lamp |-> output_short && output_isolate && !cap_to_output) else $error("lockout outputs wrong");
  a_lock_delay: assert property (
    $rose(cap_to_output) |-> ##[6:14] (fired_lockout_lamp || !key_on)) else $error("lockout not reached");
  a_lock_holds: assert property (
    fired_lockout_lamp && key_on |=> fired_lockout_lamp && !priming_lamp) else $error("lockout left early");
  a_arm_limit: assert property (
    $rose(priming_lamp) |-> ##[60:82] !priming_lamp) else $error("armed too long");
  a_abort_idle: assert property (
    abort_pulse |-> !priming_lamp && output_short && cap_short) else $error("abort left unit armed");
  a_recv_lamp: assert property (
    key_on && paging_synced |=> receiving_lamp) else $error("receiving lamp off");
endmodule
bind rexs_seq rexs_seq_sva u_sva (.core_clk(core_clk), .reset_n(reset_n), .key_on(key_on),
  .prime_cmd(prime_cmd), .fire_cmd(fire_cmd), .paging_synced(paging_synced), .output_short(output_short),
  .cap_short(cap_short), .cap_to_output(cap_to_output), .output_isolate(output_isolate),
  .priming_lamp(priming_lamp), .fired_lockout_lamp(fired_lockout_lamp),
  .receiving_lamp(receiving_lamp), .abort_pulse(abort_pulse));
`default_nettype wire

// ===== tb/rexs_pager.sv
// paging transmitter model issuing prime and fire commands
`timescale 1ns/10ps
`default_nettype none
module rexs_pager
(
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic send_prime,
  input  wire logic send_fire,
  output logic      prime_cmd,
  output logic      fire_cmd
);
  // one cycle of link delay, like the decoder path
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prime_cmd <= 1'b0;
      fire_cmd  <= 1'b0;
    end
    else
    begin
      prime_cmd <= send_prime;
      fire_cmd  <= send_fire;
    end
  end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the remote exploder sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic core_clk = 0, reset_n = 0, key_on = 0, sp = 0, sf = 0, paging_synced = 0, self_test_ok = 1;
  logic [15:0] res = 0, dres;
  logic pc, fc, osh, csh, chg, c2o, iso, plamp, flamp, pwr, rcv, don, abrt;
  int mismatches = 0, total_checks = 0, cycles = 0, aborts = 0, seed;
  rexs_pager i_pager (.core_clk(core_clk), .reset_n(reset_n), .send_prime(sp), .send_fire(sf),
    .prime_cmd(pc), .fire_cmd(fc));
  rexs_seq #(.TICK_DIV(4), .ARM_TICKS(20), .LOCK_TICKS(3), .TEST_TICKS(5)) i_dut (.core_clk(core_clk),
    .reset_n(reset_n), .key_on(key_on), .prime_cmd(pc), .fire_cmd(fc), .paging_synced(paging_synced),
    .self_test_ok(self_test_ok), .line_res_ohm(res), .output_short(osh), .cap_short(csh), .cap_charge(chg),
    .cap_to_output(c2o), .output_isolate(iso), .priming_lamp(plamp), .fired_lockout_lamp(flamp),
    .power_lamp(pwr), .receiving_lamp(rcv), .display_on(don), .display_res_ohm(dres), .abort_pulse(abrt));
  always #5 core_clk = ~core_clk;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] disp_exp(input logic k, input logic [15:0] r);
    return k ? r : 16'h0;
  endfunction
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // fire when f is set, prime otherwise; one cycle of request
  task cmd(input bit f);
    if (f)
    begin
      sf = 1;
      cyc(1);
      sf = 0;
    end
    else
    begin
      sp = 1;
      cyc(1);
      sp = 0;
    end
  endtask
  task results;
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (abrt === 1'b1)
      aborts++;
    if (cycles == 2000)
    begin
      mismatches++;
      results;
    end
  end
  initial
  begin
    seed = $urandom(32'h0a16);
    cyc(8);
    reset_n = 1;
    cyc(1);
    chk({osh, csh, plamp, flamp, don}, 16'h18);
    cmd(1);
    cyc(1);
    chk(c2o, 0);
    key_on = 1;
    cyc(2);
    chk(pwr, 0);
    cmd(1);
    cyc(1);
    chk({osh, csh, c2o}, 16'h6);
    for (int i = 0; i < 8; i++)
    begin
      res = 16'($urandom);
      paging_synced = (i == 7) ? 1'b1 : 1'($urandom);
      cyc(2);
      chk(dres, disp_exp(key_on, res));
      chk({don, rcv}, {15'h1, paging_synced});
    end
    chk(pwr, 1);
    chk({pwr, rcv}, 16'h3);
    cmd(0);
    cyc(1);
    chk({plamp, chg, osh, csh}, 16'hc);
    cyc(90);
    chk({plamp, osh, csh, 12'(aborts)}, 16'h3001);
    cmd(1);
    cyc(1);
    chk(c2o, 0);
    cmd(0);
    cmd(1);
    cyc(1);
    chk({c2o, plamp, osh}, 16'h4);
    cyc(20);
    chk({flamp, iso, osh, c2o}, 16'he);
    self_test_ok = 0;
    cmd(0);
    cmd(1);
    cyc(1);
    chk({flamp, plamp, c2o}, 16'h4);
    chk(pwr, 0);
    key_on = 0;
    cyc(2);
    chk({flamp, osh, don, pwr}, 16'h4);
    chk(dres, disp_exp(key_on, res));
    key_on = 1;
    self_test_ok = 1;
    cyc(2);
    cmd(0);
    cmd(1);
    cyc(1);
    chk(c2o, 1);
    results;
  end
endmodule
`default_nettype wire
